// ===== wiper_cascade_pkg.sv
`default_nettype none
package wiper_cascade_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int          NUM_POTS  = 4;
  localparam int          NUM_DR    = 4;
  localparam int          POS_W     = 6;
  localparam logic [5:0]  POS_MAX   = 6'h3f;
  localparam logic [5:0]  POS_MIN   = 6'h00;

  // ****************************************
  // Wiper counter field layout
  // ****************************************
  localparam int          CASCADE_BIT = 7;
  localparam int          ISOLATE_BIT = 6;
  localparam int          POS_LSB     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  WIPER_COUNTER_RESET = 8'h00;
  localparam logic [7:0]  STORED_RESET        = 8'h00;
  localparam logic [7:0]  RD_DATA_RESET       = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          NV_WRITE_MS     = 10;
  localparam int          NV_WRITE_CYCLES = (NV_WRITE_MS * CLK_HZ) / 1000;

  // ****************************************
  // Commands from the instruction decoder
  // ****************************************
  typedef enum logic [3:0] {
    CMD_WRITE_WIPER     = 4'ha,
    CMD_WRITE_STORED    = 4'hc,
    CMD_COPY_TO_WIPER   = 4'hd,
    CMD_COPY_TO_STORED  = 4'he,
    CMD_GLOBAL_TO_WIPER = 4'h1,
    CMD_GLOBAL_TO_STORE = 4'h8,
    CMD_STEP_ENABLE     = 4'h2
  } cmd_op_t;

  // Control phases
  typedef enum logic [1:0] {
    PH_RECALL = 2'b00,
    PH_RUN    = 2'b01
  } phase_t;

endpackage : wiper_cascade_pkg
`default_nettype wire

// ===== nv_write_timer.sv
`timescale 1ns/1ps
`default_nettype none

module nv_write_timer #(
  parameter int CYCLES = wiper_cascade_pkg::NV_WRITE_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  output logic      busy_out
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } timer_t;

  timer_t s_q;
  timer_t s_d;

  // Load on start, count down to zero
  always_comb begin
    s_d = s_q;
    if (start_in) begin
      s_d.count = CW'(CYCLES);
    end else if (s_q.count != '0) begin
      s_d.count = s_q.count - CW'(1);
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_out = (s_q.count != '0);

endmodule : nv_write_timer
`default_nettype wire

// ===== wiper_cascade_control.sv
// Operation
// - Data byte holds six position bits plus two control bits on top.
// - Bit 7 is cascade select; zero means normal uncascaded operation.
// - Cascade select one links a pot to the next higher-numbered pot.
// - Isolate zero enables the wiper; one disconnects it, leaving it floating.
// - Position changes by direct write, stored copy, or step command.
// - Stepping past a linked array end carries the wiper into the adjacent array; an unlinked end holds.
// - Reads return position and flags; isolate zero marks the active wiper.
// - Two, three or four pots may chain; pot 3 wraps into pot 0.
// - After reset each wiper counter loads from its stored setting zero.
// - Stored register changes are nonvolatile writes lasting up to 10 ms.
// - Each step moves one segment: up when data high, down when low.
`timescale 1ns/1ps
`default_nettype none

module wiper_cascade_control #(
  parameter int NV_WRITE_CYCLES = wiper_cascade_pkg::NV_WRITE_CYCLES
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       resetn_in,
  input  wire logic                       cmd_valid_in,
  output logic                            cmd_ready_out,
  input  wire wiper_cascade_pkg::cmd_op_t cmd_op_in,
  input  wire logic [1:0]                 cmd_pot_in,
  input  wire logic [1:0]                 cmd_reg_in,
  input  wire logic [7:0]                 cmd_data_in,
  input  wire logic                       step_valid_in,
  input  wire logic                       step_up_in,
  input  wire logic                       rd_stored_in,
  input  wire logic [1:0]                 rd_pot_in,
  input  wire logic [1:0]                 rd_reg_in,
  output logic [7:0]                      rd_data_out,
  output logic [3:0][5:0]                 wiper_pos_out,
  output logic [3:0]                      wiper_enable_out,
  output logic [3:0]                      cascade_link_out,
  output logic [1:0]                      active_pot_out,
  output logic                            nv_busy_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    wiper_cascade_pkg::phase_t phase;
    logic [3:0][7:0]           wiper;
    logic [3:0][3:0][7:0]      stored;
    logic [1:0]                act_pot;
    logic [7:0]                rd_data;
  } ctl_t;

  ctl_t s_q;
  ctl_t s_d;
  logic nv_start;
  logic nv_busy;

  // ****************************************
  // Helpers
  // ****************************************

  // Next pot in the chain, wrapping 3 into 0
  function automatic logic [1:0] next_pot(input logic [1:0] p);
    next_pot = p + 2'h1;
  endfunction : next_pot

  // Pot whose chain link lands on p
  function automatic logic [1:0] prev_pot(input logic [1:0] p);
    prev_pot = p - 2'h1;
  endfunction : prev_pot

  // Position field of a wiper counter
  function automatic logic [5:0] pos_of(input logic [7:0] w);
    pos_of = w[wiper_cascade_pkg::POS_LSB +: wiper_cascade_pkg::POS_W];
  endfunction : pos_of

  // ****************************************
  // Next-state logic
  // ****************************************

  // Command handling, stepping and read capture
  always_comb begin
    logic [1:0] p;
    logic [1:0] n;
    logic [5:0] pos;
    s_d      = s_q;
    nv_start = 1'b0;
    p        = s_q.act_pot;
    n        = 2'h0;
    pos      = pos_of(s_q.wiper[p]);

    case (s_q.phase)
      wiper_cascade_pkg::PH_RECALL: begin
        // Power-up recall, flags included
        for (int i = 0; i < wiper_cascade_pkg::NUM_POTS; i++) begin
          s_d.wiper[i] = s_q.stored[i][0];
        end
        s_d.phase = wiper_cascade_pkg::PH_RUN;
      end
      wiper_cascade_pkg::PH_RUN: begin
        // Commands win over a step in the same cycle; while the write timer
        // runs, commands wait and steps still go through
        if (cmd_valid_in && !nv_busy) begin
          case (cmd_op_in)
            wiper_cascade_pkg::CMD_WRITE_WIPER: begin
              s_d.wiper[cmd_pot_in] = cmd_data_in;
            end
            wiper_cascade_pkg::CMD_WRITE_STORED: begin
              s_d.stored[cmd_pot_in][cmd_reg_in] = cmd_data_in;
              nv_start = 1'b1;
            end
            wiper_cascade_pkg::CMD_COPY_TO_WIPER: begin
              s_d.wiper[cmd_pot_in] = s_q.stored[cmd_pot_in][cmd_reg_in];
            end
            wiper_cascade_pkg::CMD_COPY_TO_STORED: begin
              s_d.stored[cmd_pot_in][cmd_reg_in] = s_q.wiper[cmd_pot_in];
              nv_start = 1'b1;
            end
            wiper_cascade_pkg::CMD_GLOBAL_TO_WIPER: begin
              for (int i = 0; i < wiper_cascade_pkg::NUM_POTS; i++) begin
                s_d.wiper[i] = s_q.stored[i][cmd_reg_in];
              end
            end
            wiper_cascade_pkg::CMD_GLOBAL_TO_STORE: begin
              for (int i = 0; i < wiper_cascade_pkg::NUM_POTS; i++) begin
                s_d.stored[i][cmd_reg_in] = s_q.wiper[i];
              end
              nv_start = 1'b1;
            end
            wiper_cascade_pkg::CMD_STEP_ENABLE: begin
              s_d.act_pot = cmd_pot_in;
            end
            default: begin
              s_d.act_pot = s_q.act_pot;
            end
          endcase
        end else if (step_valid_in) begin
          if (step_up_in) begin
            // Toward the high terminal
            if (pos != wiper_cascade_pkg::POS_MAX) begin
              s_d.wiper[p][5:0] = pos + 6'h01;
            end else if (s_q.wiper[p][wiper_cascade_pkg::CASCADE_BIT]) begin
              n = next_pot(p);
              s_d.wiper[n][5:0] = wiper_cascade_pkg::POS_MIN;
              s_d.wiper[n][wiper_cascade_pkg::ISOLATE_BIT] = 1'b0;
              s_d.wiper[p][wiper_cascade_pkg::ISOLATE_BIT] = 1'b1;
              s_d.act_pot = n;
            end
          end else begin
            // Toward the low terminal
            // Carry down follows the link bit of the lower neighbour, since
            // the chain always links a pot to the one above it
            if (pos != wiper_cascade_pkg::POS_MIN) begin
              s_d.wiper[p][5:0] = pos - 6'h01;
            end else if (s_q.wiper[prev_pot(p)][wiper_cascade_pkg::CASCADE_BIT]) begin
              n = prev_pot(p);
              s_d.wiper[n][5:0] = wiper_cascade_pkg::POS_MAX;
              s_d.wiper[n][wiper_cascade_pkg::ISOLATE_BIT] = 1'b0;
              s_d.wiper[p][wiper_cascade_pkg::ISOLATE_BIT] = 1'b1;
              s_d.act_pot = n;
            end
          end
        end
      end
      default: begin
        s_d.phase = wiper_cascade_pkg::PH_RECALL;
      end
    endcase

    // Read port shows current position and flags, or a stored register when rd_stored_in is set
    if (rd_stored_in) begin
      s_d.rd_data = s_q.stored[rd_pot_in][rd_reg_in];
    end else begin
      s_d.rd_data = s_q.wiper[rd_pot_in];
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s_q.phase   <= wiper_cascade_pkg::PH_RECALL;
      s_q.wiper   <= {wiper_cascade_pkg::NUM_POTS{wiper_cascade_pkg::WIPER_COUNTER_RESET}};
      s_q.stored  <= {(wiper_cascade_pkg::NUM_POTS * wiper_cascade_pkg::NUM_DR)
                      {wiper_cascade_pkg::STORED_RESET}};
      s_q.act_pot <= 2'h0;
      s_q.rd_data <= wiper_cascade_pkg::RD_DATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Nonvolatile write timing
  // ****************************************
  nv_write_timer #(
    .CYCLES (NV_WRITE_CYCLES)
  ) u_nv_timer (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .start_in    (nv_start),
    .busy_out    (nv_busy)
  );

  // ****************************************
  // Outputs
  // ****************************************

  // Analog switch controls per pot
  always_comb begin
    for (int i = 0; i < wiper_cascade_pkg::NUM_POTS; i++) begin
      wiper_pos_out[i]    = pos_of(s_q.wiper[i]);
      wiper_enable_out[i] = ~s_q.wiper[i][wiper_cascade_pkg::ISOLATE_BIT];
      cascade_link_out[i] = s_q.wiper[i][wiper_cascade_pkg::CASCADE_BIT];
    end
  end

  // Ready drops for the whole write time, volatile commands included
  assign cmd_ready_out  = (s_q.phase == wiper_cascade_pkg::PH_RUN) && !nv_busy;
  assign rd_data_out    = s_q.rd_data;
  assign active_pot_out = s_q.act_pot;
  assign nv_busy_out    = nv_busy;

endmodule : wiper_cascade_control
`default_nettype wire

// ===== wiper_cascade_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module wiper_cascade_props #(parameter int NV_WRITE_CYCLES = 8) (
  input wire logic                       core_clk_in,
  input wire logic                       resetn_in,
  input wire logic                       cmd_valid_in,
  input wire logic                       cmd_ready_out,
  input wire wiper_cascade_pkg::cmd_op_t cmd_op_in,
  input wire logic [1:0]                 cmd_pot_in,
  input wire logic [7:0]                 cmd_data_in,
  input wire logic                       step_valid_in,
  input wire logic                       step_up_in,
  input wire logic                       rd_stored_in,
  input wire logic [1:0]                 rd_pot_in,
  input wire logic [7:0]                 rd_data_out,
  input wire logic [3:0][5:0]            wiper_pos_out,
  input wire logic [3:0]                 wiper_enable_out,
  input wire logic [3:0]                 cascade_link_out,
  input wire logic [1:0]                 active_pot_out,
  input wire logic                       nv_busy_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic       take, nvop, up_go, top, wr_q, rdw_q;
  logic [1:0] pot_q, ap_q;
  logic [5:0] pp_q;
  logic [7:0] dat_q, wv_q;
  // Accepted command, nonvolatile command, upward step, active wiper at top
  assign take  = cmd_valid_in && cmd_ready_out;
  assign nvop  = take && cmd_op_in inside {wiper_cascade_pkg::CMD_WRITE_STORED,
                 wiper_cascade_pkg::CMD_COPY_TO_STORED, wiper_cascade_pkg::CMD_GLOBAL_TO_STORE};
  assign up_go = step_valid_in && step_up_in && !take;
  assign top   = wiper_pos_out[active_pot_out] == 6'h3f;
  // Snapshots for the checks at the next edge
  always_ff @(posedge core_clk_in) begin
    wr_q  <= resetn_in && take && cmd_op_in == wiper_cascade_pkg::CMD_WRITE_WIPER;
    rdw_q <= resetn_in && !rd_stored_in;
    pot_q <= cmd_pot_in;
    dat_q <= cmd_data_in;
    ap_q  <= active_pot_out;
    pp_q  <= wiper_pos_out[active_pot_out];
    wv_q  <= {cascade_link_out[rd_pot_in], ~wiper_enable_out[rd_pot_in], wiper_pos_out[rd_pot_in]};
  end
  sequence s_carry; up_go && top && cascade_link_out[active_pot_out]; endsequence
  sequence s_land;
    active_pot_out == ap_q + 2'h1 && wiper_enable_out[active_pot_out] && !wiper_enable_out[ap_q]
    && wiper_pos_out[active_pot_out] == 6'h00;
  endsequence
  property p_pos; wr_q |-> wiper_pos_out[pot_q] == dat_q[5:0]; endproperty
  a_pos: assert property (p_pos) else $error("position mismatch");
  property p_link; wr_q |-> cascade_link_out[pot_q] == dat_q[7]; endproperty
  a_link: assert property (p_link) else $error("link mismatch");
  property p_iso; wr_q |-> wiper_enable_out[pot_q] == !dat_q[6]; endproperty
  a_iso: assert property (p_iso) else $error("enable mismatch");
  property p_busy; nvop |=> nv_busy_out[*7] ##[1:3] !nv_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("busy length wrong");
  property p_ready; nv_busy_out |-> !cmd_ready_out; endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  property p_step; up_go && !top |=> wiper_pos_out[ap_q] == pp_q + 6'h01; endproperty
  a_step: assert property (p_step) else $error("step not one segment");
  property p_sat; up_go && top && !cascade_link_out[active_pot_out] |=> wiper_pos_out[ap_q] == 6'h3f;
  endproperty
  a_sat: assert property (p_sat) else $error("unlinked end moved");
  property p_carry; s_carry |=> s_land; endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_rd; rdw_q |-> rd_data_out == wv_q; endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
endmodule : wiper_cascade_props
bind wiper_cascade_control wiper_cascade_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_props (
  .core_clk_in, .resetn_in, .cmd_valid_in, .cmd_ready_out, .cmd_op_in, .cmd_pot_in,
  .cmd_data_in, .step_valid_in, .step_up_in, .rd_stored_in, .rd_pot_in, .rd_data_out,
  .wiper_pos_out, .wiper_enable_out, .cascade_link_out, .active_pot_out, .nv_busy_out);
`default_nettype wire

// ===== serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host side of the command and step ports
// ****
module serial_host_model (
  input  wire logic                  core_clk_in,
  input  wire logic                  cmd_ready_in,
  output logic                       cmd_valid_out,
  output wiper_cascade_pkg::cmd_op_t cmd_op_out,
  output logic [1:0]                 cmd_pot_out,
  output logic [1:0]                 cmd_reg_out,
  output logic [7:0]                 cmd_data_out,
  output logic                       step_valid_out,
  output logic                       step_up_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_op_out = wiper_cascade_pkg::CMD_STEP_ENABLE;
    cmd_pot_out = 2'h0;
    cmd_reg_out = 2'h0;
    cmd_data_out = 8'h00;
    step_valid_out = 1'b0;
    step_up_out = 1'b0;
  end
  // Request held until ready is seen; data scrambled once released
  task automatic send(input wiper_cascade_pkg::cmd_op_t op, input logic [1:0] pot, rsel,
                      input logic [7:0] data);
    @(posedge core_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_op_out <= op;
    cmd_pot_out <= pot;
    cmd_reg_out <= rsel;
    cmd_data_out <= data;
    @(negedge core_clk_in);
    while (!cmd_ready_in) @(negedge core_clk_in);
    @(posedge core_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_data_out <= ~data;
  endtask : send
  // One step per cycle for n cycles
  task automatic step(input int n, input logic up);
    @(posedge core_clk_in);
    step_valid_out <= 1'b1;
    step_up_out <= up;
    repeat (n) @(posedge core_clk_in);
    step_valid_out <= 1'b0;
  endtask : step
endmodule : serial_host_model
`default_nettype wire

// ===== wiper_cascade_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wiper_cascade_control_tb_top;
  logic                       core_clk_in, resetn_in, cmd_valid_in, cmd_ready_out;
  logic                       step_valid_in, step_up_in, rd_stored_in, nv_busy_out;
  wiper_cascade_pkg::cmd_op_t cmd_op_in;
  logic [1:0]                 cmd_pot_in, cmd_reg_in, rd_pot_in, rd_reg_in, active_pot_out;
  logic [7:0]                 cmd_data_in, rd_data_out;
  logic [3:0][5:0]            wiper_pos_out;
  logic [3:0]                 wiper_enable_out, cascade_link_out;
  logic [7:0]                 want [4];
  int                         fails = 0, n_checks = 0, cyc = 0;
  wiper_cascade_control #(.NV_WRITE_CYCLES(8)) u_wiper_cascade_control (.core_clk_in,
    .resetn_in, .cmd_valid_in, .cmd_ready_out, .cmd_op_in, .cmd_pot_in, .cmd_reg_in,
    .cmd_data_in, .step_valid_in, .step_up_in, .rd_stored_in, .rd_pot_in, .rd_reg_in,
    .rd_data_out, .wiper_pos_out, .wiper_enable_out, .cascade_link_out, .active_pot_out,
    .nv_busy_out);
  serial_host_model u_serial_host_model (.core_clk_in, .cmd_ready_in(cmd_ready_out),
    .cmd_valid_out(cmd_valid_in), .cmd_op_out(cmd_op_in), .cmd_pot_out(cmd_pot_in),
    .cmd_reg_out(cmd_reg_in), .cmd_data_out(cmd_data_in), .step_valid_out(step_valid_in),
    .step_up_out(step_up_in));
  // Clock and hang limit
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] wv(input int p);
    return {cascade_link_out[p], ~wiper_enable_out[p], wiper_pos_out[p]};
  endfunction : wv
  // Command with the raw opcode nibble
  task automatic cmd(input logic [3:0] op, input int p, r, input logic [7:0] d);
    u_serial_host_model.send(wiper_cascade_pkg::cmd_op_t'(op), 2'(p), 2'(r), d);
  endtask : cmd
  task automatic rchk(input logic st, input int p, r, input logic [7:0] exp);
    @(posedge core_clk_in);
    rd_stored_in <= st;
    rd_pot_in <= 2'(p);
    rd_reg_in <= 2'(r);
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk("read", exp, rd_data_out);
  endtask : rchk
  task automatic t_fields;
    for (int p = 0; p < 4; p++) begin
      want[p] = {p[0], p[1], 6'h11 + 6'(p)};
      cmd(4'ha, p, 0, want[p]);
      @(negedge core_clk_in);
      chk("fields", want[p], wv(p));
      rchk(1'b0, p, 0, want[p]);
    end
    $display("t_fields done");
  endtask : t_fields
  task automatic t_nv;
    cmd(4'hc, 1, 2, 8'hc5);
    @(negedge core_clk_in);
    chk("busy", 8'h01, {7'h00, nv_busy_out & ~cmd_ready_out});
    cmd(4'hd, 1, 2, 8'h00);
    @(negedge core_clk_in);
    want[1] = 8'hc5;
    chk("copy", want[1], wv(1));
    rchk(1'b1, 1, 2, 8'hc5);
    cmd(4'he, 2, 3, 8'h00);
    rchk(1'b1, 2, 3, want[2]);
    cmd(4'h8, 0, 1, 8'h00);
    for (int p = 0; p < 4; p++) cmd(4'ha, p, 0, 8'h40);
    cmd(4'h1, 0, 1, 8'h00);
    @(negedge core_clk_in);
    for (int p = 0; p < 4; p++) chk("global", want[p], wv(p));
    $display("t_nv done");
  endtask : t_nv
  task automatic t_carry;
    cmd(4'ha, 3, 0, 8'hbe);
    cmd(4'ha, 0, 0, 8'h40);
    cmd(4'h2, 3, 0, 8'h00);
    u_serial_host_model.step(2, 1'b1);
    @(negedge core_clk_in);
    chk("up pot 3", 8'hff, wv(3));
    chk("up pot 0", 8'h00, wv(0));
    chk("up active", 8'h00, {6'h00, active_pot_out});
    u_serial_host_model.step(1, 1'b0);
    @(negedge core_clk_in);
    chk("down pot 3", 8'hbf, wv(3));
    chk("down pot 0", 8'h40, wv(0));
    chk("down active", 8'h03, {6'h00, active_pot_out});
    u_serial_host_model.step(1, 1'b0);
    @(negedge core_clk_in);
    chk("step down", 8'hbe, wv(3));
    cmd(4'ha, 1, 0, 8'h3f);
    cmd(4'h2, 1, 0, 8'h00);
    u_serial_host_model.step(1, 1'b1);
    @(negedge core_clk_in);
    chk("end", 8'h3f, wv(1));
    $display("t_carry done");
  endtask : t_carry
  task automatic t_recall;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    for (int p = 0; p < 4; p++) chk("recall", 8'h00, wv(p));
    $display("t_recall done");
  endtask : t_recall
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Reset, recall check, then the scenarios
  initial begin
    resetn_in = 1'b0;
    rd_stored_in = 1'b0;
    rd_pot_in = 2'h0;
    rd_reg_in = 2'h0;
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    t_recall();
    t_fields();
    t_nv();
    t_carry();
    tally_and_finish();
  end
endmodule : wiper_cascade_control_tb_top
`default_nettype wire
